// [verif/host_bus_model.sv]
// host processor model driving the byte bus of the clock core
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
    // clock and device answers
    input  wire logic          clock,
    input  wire logic          host_ready,
    input  wire logic [7:0]    host_rdata,
    // request to the device
    output var rtc_pkg::host_req_t host_req
);
    // one-cycle strobe launched off the sampling edge; idle bus shows inverted stale values
    // so a design that latches outside the strobe sees garbage
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        do @(negedge clock); while (host_ready !== 1'b1); // idle cycle between strobes
        host_req = '{rd: rd, wr: !rd, addr: a, wdata: d};
        @(negedge clock);
        q = host_rdata;
        host_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // nothing requested before the first transfer
    initial host_req = '0;
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench of the clock core against a byte-map and calendar model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic               clock = 1'b0;
    logic               rst = 1'b1;
    logic               osc_input_pin = 1'b0;
    logic               power_good = 1'b0;
    rtc_pkg::host_req_t host_req;
    logic [7:0]         host_rdata;
    logic               host_ready;
    logic               alarm_event;
    logic               update_pending_flag;
    logic [7:0]         q;
    logic [6:0]         a;
    int                 n_errors = 0;
    int                 n_compared = 0;
    int                 cycles = 0;
    int                 mdl [128];

    always #25 clock = ~clock;
    // fast timebase: the true rate would need twenty million cycles per second
    always @(negedge clock) osc_input_pin <= ~osc_input_pin;

    rtc_core #(.REC_CYCLES(16)) rtc_core_i (
        .clock(clock), .rst(rst), .osc_input_pin(osc_input_pin), .power_good(power_good),
        .host_req(host_req), .host_rdata(host_rdata), .host_ready(host_ready),
        .alarm_event(alarm_event), .update_pending_flag(update_pending_flag));
    host_bus_model host_bus_model_i (
        .clock(clock), .host_ready(host_ready), .host_rdata(host_rdata), .host_req(host_req));

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // writes update the model with the read-only parts left out
    task automatic wr(input logic [6:0] wa, input logic [7:0] d);
        host_bus_model_i.xfer(1'b0, wa, d, q);
        if (wa == rtc_pkg::ADDR_SEC || wa == rtc_pkg::ADDR_RATE)
            mdl[wa] = d & 8'h7f;
        else if (wa != rtc_pkg::ADDR_FLAGS && wa != rtc_pkg::ADDR_VALID)
            mdl[wa] = d;
    endtask

    task automatic rd(input logic [6:0] ra);
        host_bus_model_i.xfer(1'b1, ra, 8'h00, q);
        check($sformatf("byte %h", ra), q, mdl[ra][7:0]);
    endtask

    // one second in binary 24-hour form, leap year every fourth year
    function automatic void advance();
        int dim;
        dim = (mdl[8] inside {4, 6, 9, 11}) ? 30 : 31;
        if (mdl[8] == 2)
            dim = (mdl[9] % 4 == 0) ? 29 : 28;
        mdl[0]++;
        if (mdl[0] > 59) mdl[2]++;
        if (mdl[0] > 59) mdl[0] = 0;
        if (mdl[2] > 59) mdl[4]++;
        if (mdl[2] > 59) mdl[2] = 0;
        if (mdl[4] > 23) mdl[6] = mdl[6] % 7 + 1;
        if (mdl[4] > 23) mdl[7]++;
        if (mdl[4] > 23) mdl[4] = 0;
        if (mdl[7] > dim) mdl[8]++;
        if (mdl[7] > dim) mdl[7] = 1;
    endfunction

    // wait through one update, then compare alarm, time bytes, rate and flags
    task automatic check_update();
        mdl[12] = 8'hb0;
        while (update_pending_flag !== 1'b1) @(negedge clock);
        mdl[10] = mdl[10] | 8'h80;
        rd(rtc_pkg::ADDR_RATE);
        mdl[10] = mdl[10] & 8'h7f;
        for (int k = 0; k < 64 && alarm_event !== 1'b1; k++) @(negedge clock);
        check("alarm_event", {7'h00, alarm_event}, 8'h01);
        for (int i = 0; i < 11; i++)
            rd(7'(i));
        rd(rtc_pkg::ADDR_FLAGS);
        mdl[12] = 0;
        rd(rtc_pkg::ADDR_FLAGS);
    endtask

    // hang guard, above two half-second countdowns of the fast timebase
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            n_errors = n_errors + 1;
            print_verdict();
        end
    end

    initial begin
        void'($urandom(26));
        foreach (mdl[i]) mdl[i] = 0;
        mdl[13] = 8'h80;
        repeat (16) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        power_good = 1'b1;
        check("host_ready", {7'h00, host_ready}, 8'h00);
        wr(rtc_pkg::ADDR_VALID, 8'h00);
        rd(rtc_pkg::ADDR_VALID);
        for (int i = 0; i < 4; i++) begin
            a = 7'(14 + $urandom % 114);
            wr(a, 8'($urandom));
            rd(a);
        end
        $display("test map done");
        wr(rtc_pkg::ADDR_MODE, 8'h86);
        for (int i = 0; i < 10; i++)
            wr(7'(i), (i % 2 == 1 && i < 6) ? 8'($urandom) | 8'hc0 : 8'h00);
        wr(7'h00, 8'hbb);
        wr(7'h02, 8'h3b);
        wr(7'h04, 8'h17);
        wr(7'h06, 8'h07);
        wr(7'h07, 8'h1c);
        wr(7'h08, 8'h02);
        wr(7'h09, 8'h04);
        rd(7'h00);
        wr(rtc_pkg::ADDR_RATE, 8'he0);
        rd(rtc_pkg::ADDR_RATE);
        wr(rtc_pkg::ADDR_RATE, 8'h20);
        wr(rtc_pkg::ADDR_MODE, 8'h26);
        advance();
        check_update();
        $display("test calendar done");
        // supply dip with the chain running: access waits out the recovery time
        power_good = 1'b0;
        repeat (8) @(negedge clock);
        check("host_ready", {7'h00, host_ready}, 8'h00);
        power_good = 1'b1;
        repeat (8) @(negedge clock);
        check("host_ready", {7'h00, host_ready}, 8'h00);
        rd(rtc_pkg::ADDR_MODE);
        $display("test power done");
        // bcd and 12-hour: 11:59:59 pm on the last of april, all ten bytes rewritten
        wr(rtc_pkg::ADDR_MODE, 8'ha0);
        wr(rtc_pkg::ADDR_RATE, 8'h60);
        for (int i = 1; i < 6; i += 2)
            wr(7'(i), 8'($urandom) | 8'hc0);
        wr(7'h00, 8'h59);
        wr(7'h02, 8'h59);
        wr(7'h04, 8'h91);
        wr(7'h06, 8'h03);
        wr(7'h07, 8'h30);
        wr(7'h08, 8'h04);
        wr(7'h09, 8'h99);
        wr(rtc_pkg::ADDR_RATE, 8'h20);
        wr(rtc_pkg::ADDR_MODE, 8'h20);
        // one second on: 12 am on the first of may, weekday advanced
        mdl[0] = 8'h00;
        mdl[2] = 8'h00;
        mdl[4] = 8'h12;
        mdl[6] = 8'h04;
        mdl[7] = 8'h01;
        mdl[8] = 8'h05;
        check_update();
        $display("test bcd 12-hour done");
        print_verdict();
    end
endmodule
`default_nettype wire

// [verilog/rtc_core.sv]
// real-time clock core: timebase, calendar, alarm, byte map and power gate
`timescale 1ns/100ps
`default_nettype none
module rtc_core #(
    parameter int unsigned REC_CYCLES = rtc_pkg::REC_CYCLES
) (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rst,
    // pins from outside the clock domain
    input  wire logic               osc_input_pin,
    input  wire logic               power_good,
    // host byte bus
    input  wire rtc_pkg::host_req_t host_req,
    output logic [7:0]              host_rdata,
    output logic                    host_ready,
    // status
    output logic                    alarm_event,
    output logic                    update_pending_flag
);

    typedef struct packed {
        logic                    osc_s1;
        logic                    osc_s2;
        logic                    osc_prev;
        logic                    pwr_s1;
        logic                    pwr_s2;
        logic                    pwr_prev;
        rtc_pkg::pwr_state_t     pstate;
        logic [31:0]             rec_cnt;
        logic [14:0]             div;
        logic [9:0][7:0]         tcal;
        logic [7:0]              rate;
        logic [7:0]              mode;
        logic                    af;
        logic                    uf;
        logic [113:0][7:0]       ram;
        logic [7:0]              rdata;
        logic                    ready;
        logic                    alarm_event;
        logic                    pending;
    } state_t;

    state_t s;
    state_t next_s;

    // bcd or binary byte to binary
    function automatic logic [7:0] dec(input logic [7:0] v, input logic dm);
        dec = dm ? v : ({4'h0, v[7:4]} * rtc_pkg::BCD_TEN) + {4'h0, v[3:0]};
    endfunction

    // binary to bcd or binary byte
    function automatic logic [7:0] enc(input logic [7:0] v, input logic dm);
        logic [7:0] t;
        logic [7:0] o;
        t = v / rtc_pkg::BCD_TEN;
        o = v - t * rtc_pkg::BCD_TEN;
        enc = dm ? v : {t[3:0], o[3:0]};
    endfunction

    // days in a month, binary month and year
    function automatic logic [7:0] days_in(input logic [7:0] mo, input logic [7:0] yr);
        case (mo)
            rtc_pkg::MON_FEB: days_in = (yr[1:0] == 2'h0) ? rtc_pkg::DAYS_29
                                                          : rtc_pkg::DAYS_28;
            rtc_pkg::MON_APR, rtc_pkg::MON_JUN,
            rtc_pkg::MON_SEP, rtc_pkg::MON_NOV: days_in = rtc_pkg::DAYS_30;
            default: days_in = rtc_pkg::DAYS_31;
        endcase
    endfunction

    // alarm byte against time byte, top two bits set match anything
    function automatic logic amatch(input logic [7:0] al, input logic [7:0] tm);
        amatch = ((al & rtc_pkg::DC_MASK) == rtc_pkg::DC_MASK) || (al == tm);
    endfunction

    logic       dm;
    logic       h24;
    logic       osc_edge;
    logic       pwr_rise;
    logic       sec_tick;
    logic       do_update;
    logic       osc_on;
    logic       hit;
    logic [6:0] ram_idx;
    logic [7:0] sec;
    logic [7:0] mins;
    logic [7:0] hr;
    logic [7:0] wd;
    logic [7:0] dt;
    logic [7:0] mo;
    logic [7:0] yr;
    logic [7:0] hv;
    logic [7:0] h_out;

    // whole next state in one place
    always_comb begin
        next_s = s;
        dm = s.mode[rtc_pkg::B_DM];
        h24 = s.mode[rtc_pkg::B_24H];
        sec = 8'h00;
        mins = 8'h00;
        hr = 8'h00;
        wd = 8'h00;
        dt = 8'h00;
        mo = 8'h00;
        yr = 8'h00;
        hv = 8'h00;
        h_out = 8'h00;
        hit = 1'b0;
        sec_tick = 1'b0;
        ram_idx = s_addr_ram(host_req.addr);
        next_s.alarm_event = 1'b0;

        // pin synchronisers; only the second stage and its delayed copy are looked at
        next_s.osc_s1 = osc_input_pin;
        next_s.osc_s2 = s.osc_s1;
        next_s.osc_prev = s.osc_s2;
        next_s.pwr_s1 = power_good;
        next_s.pwr_s2 = s.pwr_s1;
        next_s.pwr_prev = s.pwr_s2;
        osc_edge = s.osc_s2 & ~s.osc_prev;
        pwr_rise = s.pwr_s2 & ~s.pwr_prev;
        osc_on = (s.rate[6:4] == rtc_pkg::DV_RUN) || (s.rate[6:5] == rtc_pkg::DV_HOLD);

        // countdown chain: 32768 timebase edges per second
        if (s.rate[6:5] == rtc_pkg::DV_HOLD) begin
            next_s.div = rtc_pkg::DIV_HALF;  // first update half a second after release
        end else if (s.rate[6:4] == rtc_pkg::DV_RUN && osc_edge) begin
            next_s.div = s.div + 15'h0001;
            sec_tick = (s.div == rtc_pkg::DIV_LAST);
        end
        do_update = sec_tick && !s.mode[rtc_pkg::B_SET];
        next_s.pending = (s.rate[6:4] == rtc_pkg::DV_RUN) && !s.mode[rtc_pkg::B_SET]
                         && (next_s.div >= rtc_pkg::DIV_LEAD);

        // read side, clearing flags before any new event sets them
        if (host_req.rd && s.ready) begin
            if (host_req.addr < rtc_pkg::ADDR_RATE) begin
                next_s.rdata = s.tcal[host_req.addr[3:0]];
            end else if (host_req.addr == rtc_pkg::ADDR_RATE) begin
                next_s.rdata = {s.pending, s.rate[6:0]};
            end else if (host_req.addr == rtc_pkg::ADDR_MODE) begin
                next_s.rdata = s.mode;
            end else if (host_req.addr == rtc_pkg::ADDR_FLAGS) begin
                next_s.rdata = 8'h00;
                next_s.rdata[rtc_pkg::C_IRQF] = (s.af & s.mode[rtc_pkg::B_AIE])
                                                | (s.uf & s.mode[rtc_pkg::B_UIE]);
                next_s.rdata[rtc_pkg::C_AF] = s.af;
                next_s.rdata[rtc_pkg::C_UF] = s.uf;
                next_s.af = 1'b0;
                next_s.uf = 1'b0;
            end else if (host_req.addr == rtc_pkg::ADDR_VALID) begin
                next_s.rdata = rtc_pkg::VALID_VALUE;
            end else begin
                next_s.rdata = s.ram[ram_idx];
            end
        end

        // once-per-second advance in the selected format
        if (do_update) begin
            sec = dec(s.tcal[rtc_pkg::I_SEC], dm);
            mins = dec(s.tcal[rtc_pkg::I_MIN], dm);
            wd = dec(s.tcal[rtc_pkg::I_WDAY], dm);
            dt = dec(s.tcal[rtc_pkg::I_DATE], dm);
            mo = dec(s.tcal[rtc_pkg::I_MON], dm);
            yr = dec(s.tcal[rtc_pkg::I_YEAR], dm);
            hv = dec(s.tcal[rtc_pkg::I_HR] & rtc_pkg::LOW7_MASK, dm);
            if (h24) begin
                hr = dec(s.tcal[rtc_pkg::I_HR], dm);
            end else begin  // 12 am is hour zero
                hr = ((hv == rtc_pkg::HALF_DAY) ? 8'h00 : hv)
                     + (s.tcal[rtc_pkg::I_HR][7] ? rtc_pkg::HALF_DAY : 8'h00);
            end
            if (sec >= rtc_pkg::SEC_MAX) begin
                sec = 8'h00;
                if (mins >= rtc_pkg::SEC_MAX) begin
                    mins = 8'h00;
                    if (hr >= rtc_pkg::HOUR_MAX) begin
                        hr = 8'h00;
                        wd = (wd >= rtc_pkg::WDAY_MAX) ? rtc_pkg::ONE : wd + rtc_pkg::ONE;
                        if (dt >= days_in(mo, yr)) begin
                            dt = rtc_pkg::ONE;
                            if (mo >= rtc_pkg::MON_MAX) begin
                                mo = rtc_pkg::ONE;
                                yr = (yr >= rtc_pkg::YEAR_MAX) ? 8'h00 : yr + rtc_pkg::ONE;
                            end else begin
                                mo = mo + rtc_pkg::ONE;
                            end
                        end else begin
                            dt = dt + rtc_pkg::ONE;
                        end
                    end else begin
                        hr = hr + rtc_pkg::ONE;
                    end
                end else begin
                    mins = mins + rtc_pkg::ONE;
                end
            end else begin
                sec = sec + rtc_pkg::ONE;
            end
            if (h24) begin
                h_out = enc(hr, dm);
            end else begin  // back to 1..12 with pm in bit 7
                hv = (hr >= rtc_pkg::HALF_DAY) ? hr - rtc_pkg::HALF_DAY : hr;
                hv = (hv == 8'h00) ? rtc_pkg::HALF_DAY : hv;
                h_out = enc(hv, dm);
                h_out[7] = (hr >= rtc_pkg::HALF_DAY);
            end
            next_s.tcal[rtc_pkg::I_SEC] = enc(sec, dm);
            next_s.tcal[rtc_pkg::I_MIN] = enc(mins, dm);
            next_s.tcal[rtc_pkg::I_HR] = h_out;
            next_s.tcal[rtc_pkg::I_WDAY] = enc(wd, dm);
            next_s.tcal[rtc_pkg::I_DATE] = enc(dt, dm);
            next_s.tcal[rtc_pkg::I_MON] = enc(mo, dm);
            next_s.tcal[rtc_pkg::I_YEAR] = enc(yr, dm);
            next_s.uf = 1'b1;
            // alarm check runs on the freshly advanced time
            hit = amatch(s.tcal[rtc_pkg::I_SEC_A], next_s.tcal[rtc_pkg::I_SEC])
                  && amatch(s.tcal[rtc_pkg::I_MIN_A], next_s.tcal[rtc_pkg::I_MIN])
                  && amatch(s.tcal[rtc_pkg::I_HR_A], next_s.tcal[rtc_pkg::I_HR]);
            if (hit) begin
                next_s.af = 1'b1;
                next_s.alarm_event = s.mode[rtc_pkg::B_AIE];
            end
        end

        // host writes land last, so a load in the update cycle is kept
        if (host_req.wr && s.ready) begin
            if (host_req.addr == rtc_pkg::ADDR_SEC) begin
                next_s.tcal[rtc_pkg::I_SEC] = host_req.wdata & rtc_pkg::SEC_WR_MASK;
            end else if (host_req.addr <= rtc_pkg::ADDR_YEAR) begin
                next_s.tcal[host_req.addr[3:0]] = host_req.wdata;
            end else if (host_req.addr == rtc_pkg::ADDR_RATE) begin
                next_s.rate = {1'b0, host_req.wdata[6:0]};  // bit 7 is status
            end else if (host_req.addr == rtc_pkg::ADDR_MODE) begin
                next_s.mode = host_req.wdata;
            end else if (host_req.addr >= rtc_pkg::ADDR_RAM) begin
                next_s.ram[ram_idx] = host_req.wdata;
            end
        end

        // power-up access gate
        case (s.pstate)
            rtc_pkg::PWR_OFF: begin
                if (pwr_rise) begin
                    if (s.rate[6:4] == rtc_pkg::DV_RUN) begin  // wait out recovery
                        next_s.pstate = rtc_pkg::PWR_RECOVER;
                        next_s.rec_cnt = 32'h0000_0000;
                    end else begin
                        if (!osc_on) begin
                            next_s.rate[6:4] = rtc_pkg::DV_RUN;
                        end
                        next_s.pstate = rtc_pkg::PWR_READY;
                    end
                end
            end
            rtc_pkg::PWR_RECOVER: begin
                if (!s.pwr_s2) begin
                    next_s.pstate = rtc_pkg::PWR_OFF;
                end else if (s.rec_cnt >= REC_CYCLES - 1) begin
                    next_s.pstate = rtc_pkg::PWR_READY;
                end else begin
                    next_s.rec_cnt = s.rec_cnt + 32'h0000_0001;
                end
            end
            rtc_pkg::PWR_READY: begin
                if (!s.pwr_s2) begin
                    next_s.pstate = rtc_pkg::PWR_OFF;
                end
            end
            default: next_s.pstate = rtc_pkg::PWR_OFF;
        endcase
        next_s.ready = (next_s.pstate == rtc_pkg::PWR_READY);
    end

    // ram offset from a bus address
    function automatic logic [6:0] s_addr_ram(input logic [6:0] a);
        s_addr_ram = a - rtc_pkg::ADDR_RAM;
    endfunction

    // reset models first power-up: defined values instead of unknown contents
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.rate <= rtc_pkg::RATE_RESET;
            s.mode <= rtc_pkg::MODE_RESET;
            s.pstate <= rtc_pkg::PWR_OFF;
        end else begin
            s <= next_s;
        end
    end

    assign host_rdata = s.rdata;
    assign host_ready = s.ready;
    assign alarm_event = s.alarm_event;
    assign update_pending_flag = s.pending;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // checks on the access gate, countdown chain, byte map and alarm path
    a_pending_off: assert property (s.mode[rtc_pkg::B_SET] |=> !update_pending_flag)
        else $error("update pending shown while inhibited");
    a_supply_drop: assert property (!s.pwr_s2 |=> !host_ready)
        else $error("host access open with supply low");
    a_gate_recover: assert property (s.pstate == rtc_pkg::PWR_RECOVER |-> !host_ready)
        else $error("host access open during recovery");
    a_gate_osc_on: assert property (
        (s.pstate == rtc_pkg::PWR_OFF && pwr_rise && !osc_on)
        |=> (s.rate[6:4] == rtc_pkg::DV_RUN) && host_ready)
        else $error("stopped oscillator not enabled at power-up");
    a_hold_chain: assert property ((s.rate[6:5] == rtc_pkg::DV_HOLD)
        |=> s.div == rtc_pkg::DIV_HALF)
        else $error("chain not held in reset");
    a_stop_count: assert property ((s.rate[6:4] != rtc_pkg::DV_RUN) |-> !sec_tick)
        else $error("second advanced while not running");
    a_inhibit_hold: assert property (
        (s.mode[rtc_pkg::B_SET] && !host_req.wr) |=> $stable(s.tcal))
        else $error("time changed while update inhibited");
    a_sec_msb_zero: assert property (!s.tcal[rtc_pkg::I_SEC][7])
        else $error("seconds msb not zero");
    a_rate_msb_ro: assert property (!s.rate[7])
        else $error("rate register bit 7 stored");
    a_alarm_all_dc: assert property (
        (do_update && s.mode[rtc_pkg::B_AIE]
         && ((s.tcal[rtc_pkg::I_SEC_A] & s.tcal[rtc_pkg::I_MIN_A] & s.tcal[rtc_pkg::I_HR_A]
              & rtc_pkg::DC_MASK) == rtc_pkg::DC_MASK))
        |=> alarm_event ##1 !alarm_event)
        else $error("per-second alarm missing");
    a_mode_kept: assert property ((!host_req.wr) |=> $stable(s.mode))
        else $error("mode byte changed internally");
    a_alarm_flag: assert property (alarm_event |-> s.af && $past(s.mode[rtc_pkg::B_AIE]))
        else $error("alarm event without flag");

    c_alarm: cover property (alarm_event);
    c_ready: cover property ($rose(host_ready));
    c_update: cover property (do_update ##1 update_pending_flag == 1'b0);
    c_recover: cover property (s.pstate == rtc_pkg::PWR_RECOVER);
    c_flags_read: cover property (host_req.rd && host_ready && host_req.addr == rtc_pkg::ADDR_FLAGS);

endmodule
`default_nettype wire

// [verilog/rtc_pkg.sv]
// constants, field layout and shared types of the real-time clock core
// Notes on behaviour
// - all timekeeping comes from a 32.768 kHz timebase on the oscillator input pin
// - the oscillator runs or stops only under the divider field of the rate register
// - on power-up, hold access for recovery time if running, else enable oscillator
// - the ten time, calendar and alarm bytes are held in binary or BCD
// - every count update uses the currently selected data format
// - in 12-hour mode hours bit 7 is the pm indicator, hours run 1 to 12
// - weekday increments at midnight, cycling 1 to 7, 1 being Sunday
// - date rolls over correctly for short months and leap-year February
// - bytes are double-buffered so host access never stalls counting; the core has one copy, read and written directly
// - once a second advance the seven time bytes, then compare with alarm
// - exact alarm bytes raise the alarm event daily on match when enabled
// - an alarm byte with both top bits set matches any time value
// - don't-care codes give hourly, per-minute or per-second alarms
// - a 128-byte map is read and written directly, bar read-only parts
// - writes to flags, valid-RAM, rate bit 7 and seconds bit 7 are ignored
// - fixed-zero bits of time bytes other than seconds accept written ones
// - data format select 1 means binary, 0 BCD; nothing internal changes it
// - hour mode control 1 means 24-hour, 0 means 12-hour
// - only divider field 010 keeps time; 11x runs oscillator, holds chain reset
// - while update inhibit is set no once-per-second transfer occurs
package rtc_pkg;

    // clock and timebase
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned OSC_HZ      = 32_768;
    localparam int unsigned REC_TIME_MS = 200;
    localparam int unsigned REC_CYCLES  = REC_TIME_MS * (CLK_HZ / 1000);

    // address map
    localparam logic [6:0] ADDR_SEC   = 7'h00;
    localparam logic [6:0] ADDR_HOUR  = 7'h04;
    localparam logic [6:0] ADDR_YEAR  = 7'h09;
    localparam logic [6:0] ADDR_RATE  = 7'h0a;
    localparam logic [6:0] ADDR_MODE  = 7'h0b;
    localparam logic [6:0] ADDR_FLAGS = 7'h0c;
    localparam logic [6:0] ADDR_VALID = 7'h0d;
    localparam logic [6:0] ADDR_RAM   = 7'h0e;
    localparam int unsigned TIME_BYTES = 10;
    localparam int unsigned RAM_BYTES  = 114;

    // byte indices inside the time block
    localparam int unsigned I_SEC   = 0;
    localparam int unsigned I_SEC_A = 1;
    localparam int unsigned I_MIN   = 2;
    localparam int unsigned I_MIN_A = 3;
    localparam int unsigned I_HR    = 4;
    localparam int unsigned I_HR_A  = 5;
    localparam int unsigned I_WDAY  = 6;
    localparam int unsigned I_DATE  = 7;
    localparam int unsigned I_MON   = 8;
    localparam int unsigned I_YEAR  = 9;

    // rate/divider control fields
    localparam int unsigned A_PENDING = 7;
    localparam logic [2:0]  DV_RUN    = 3'h2;
    localparam logic [1:0]  DV_HOLD   = 2'h3;
    localparam logic [7:0]  RATE_RESET = 8'h00;

    // mode/enable control fields
    localparam int unsigned B_SET  = 7;
    localparam int unsigned B_AIE  = 5;
    localparam int unsigned B_UIE  = 4;
    localparam int unsigned B_DM   = 2;
    localparam int unsigned B_24H  = 1;
    localparam logic [7:0]  MODE_RESET = 8'h00;

    // event flag and valid-RAM layout
    localparam int unsigned C_IRQF = 7;
    localparam int unsigned C_AF   = 5;
    localparam int unsigned C_UF   = 4;
    localparam logic [7:0]  VALID_VALUE = 8'h80;

    // masks and calendar limits, binary
    localparam logic [7:0] SEC_WR_MASK = 8'h7f;
    localparam logic [7:0] DC_MASK     = 8'hc0;
    localparam logic [7:0] LOW7_MASK   = 8'h7f;
    localparam logic [7:0] SEC_MAX     = 8'h3b;
    localparam logic [7:0] HOUR_MAX    = 8'h17;
    localparam logic [7:0] HALF_DAY    = 8'h0c;
    localparam logic [7:0] WDAY_MAX    = 8'h07;
    localparam logic [7:0] MON_MAX     = 8'h0c;
    localparam logic [7:0] YEAR_MAX    = 8'h63;
    localparam logic [7:0] MON_FEB     = 8'h02;
    localparam logic [7:0] MON_APR     = 8'h04;
    localparam logic [7:0] MON_JUN     = 8'h06;
    localparam logic [7:0] MON_SEP     = 8'h09;
    localparam logic [7:0] MON_NOV     = 8'h0b;
    localparam logic [7:0] DAYS_31     = 8'h1f;
    localparam logic [7:0] DAYS_30     = 8'h1e;
    localparam logic [7:0] DAYS_29     = 8'h1d;
    localparam logic [7:0] DAYS_28     = 8'h1c;
    localparam logic [7:0] BCD_TEN     = 8'h0a;
    localparam logic [7:0] ONE         = 8'h01;

    // countdown chain, one second per full turn
    localparam logic [14:0] DIV_HALF = 15'h4000;
    localparam logic [14:0] DIV_LAST = 15'h7fff;
    localparam logic [14:0] DIV_LEAD = 15'h7ff8;

    // power/access sequence, gray along off -> recover -> ready
    typedef enum logic [1:0] {
        PWR_OFF     = 2'h0,
        PWR_RECOVER = 2'h1,
        PWR_READY   = 2'h3
    } pwr_state_t;

    // one host bus request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } host_req_t;

endpackage
